/* shared/igc_defs.svh */
// Constants for the interrupt and general control register
// Behaviour
// RULE1 - The control register is one 16-bit I/O port location decoded at port 0x38.
// RULE2 - The low eight bits are the service enable mask; a set bit lets its interrupt be serviced.
// RULE3 - Mask bit 0 is interrupt zero (highest priority) up to bit 7, interrupt seven (lowest).
// RULE4 - Bit 0 is converter timer underflow, bits 1 and 2 the timer underflows, bit 5 port fall.
// RULE5 - While reset is asserted the whole register is held at zero.
// RULE6 - Bits 8 and 9 pick each timer's clock: clear is half master clock, set is oscillator.
// RULE7 - Bits 10 and 11 run the first and second timer; one starts, zero stops.
// RULE8 - Bit 12 engages the pull-ups on all eight dedicated input pins together.
// RULE9 - Bit 13 picks the pulse-density clock: clear is half master clock, set is full rate.
// RULE10 - Bit 14 arms asynchronous wake from interrupts during sleep.
// RULE11 - Software sets the wake arm bit before idling if the master clock will stop.
// RULE12 - Bit 15 enables the comparator and switches related inputs to comparator mode.
// RULE13 - A flag is set on its trigger; if its mask bit is set it is serviced and cleared.
// RULE14 - With the comparator on, interrupt six fires on a rise, seven on a fall that may start timer one.
// RULE15 - A port write updates all 16 bits in one cycle and a read returns all 16 bits.
`ifndef IGC_DEFS_SVH
`define IGC_DEFS_SVH
`define IGC_ADDR_W        8
`define IGC_CTRL_ADDR     8'h38
`define IGC_FLAG_ADDR     8'h39
`define IGC_CTRL_RESET    16'h0000
`define IGC_NUM_IRQ       8
`define IGC_IRQ_SIX       3'h6
`define IGC_IRQ_SEVEN     3'h7
`define IGC_BIT_T1_CLK    8
`define IGC_BIT_T2_CLK    9
`define IGC_BIT_T1_RUN    10
`define IGC_BIT_T2_RUN    11
`define IGC_BIT_PULLUP    12
`define IGC_BIT_PDM       13
`define IGC_BIT_WAKE      14
`define IGC_BIT_COMP      15
`endif

/* shared/igc_pkg.sv */
// Types shared by the interrupt and general control register
`default_nettype none
package igc_pkg;
	typedef struct packed {
		logic       comp_enable;
		logic       async_wake_arm;
		logic       pdm_rate_select;
		logic       input_pullup_on;
		logic       second_timer_run;
		logic       first_timer_run;
		logic       second_timer_clk_sel;
		logic       first_timer_clk_sel;
		logic [7:0] service_enable_mask;
	} igc_ctrl_type;
	typedef struct packed {
		logic       comp_out;
		logic       pin4;
		logic       pin5;
	} igc_pins_type;
endpackage
`default_nettype wire

/* hw/igc_ctrl.sv */
// Interrupt and general control register with its flag logic
`include "igc_defs.svh"
`default_nettype none
module igc_ctrl
	import igc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                   mclk_in,
	input  wire logic                   srst_in,
	input  wire logic                   ce_in,
	// I/O port bus
	input  wire logic [`IGC_ADDR_W-1:0] port_addr_in,
	input  wire logic                   port_wr_in,
	input  wire logic                   port_rd_in,
	input  wire logic [15:0]            port_wdata_in,
	output logic      [15:0]            port_rdata_out,
	// Interrupt trigger sources
	input  wire logic                   converter_timer_underflow_irq_in,
	input  wire logic                   first_timer_underflow_irq_in,
	input  wire logic                   second_timer_underflow_irq_in,
	input  wire logic [1:0]             pin_edge_irq_in,
	input  wire logic                   input_port_fall_irq_in,
	input  wire igc_pins_type           pins_in,
	// Control outputs
	output igc_ctrl_type                ctrl_out,
	output logic                        first_timer_active_out,
	output logic [7:0]                  interrupt_flag_out,
	output logic [7:0]                  service_out
);

	// ******************************
	// Decode
	// ******************************
	igc_ctrl_type ctrl;
	igc_pins_type pins_prev;
	logic [7:0]   flags;
	logic         t1_cmp_run;
	wire          wr_ctrl = port_wr_in && (port_addr_in == `IGC_CTRL_ADDR); // [RULE1]
	wire          wr_flag = port_wr_in && (port_addr_in == `IGC_FLAG_ADDR);
	wire          rd_ctrl = port_rd_in && (port_addr_in == `IGC_CTRL_ADDR);
	wire          rd_flag = port_rd_in && (port_addr_in == `IGC_FLAG_ADDR);

	// ******************************
	// Comparator edges
	// ******************************
	// Comparator mode takes both edges from the comparator output
	wire rise6 = ctrl.comp_enable ? (pins_in.comp_out && !pins_prev.comp_out)
	                              : (pins_in.pin4 && !pins_prev.pin4); // [RULE12] [RULE14]
	wire fall7 = ctrl.comp_enable ? (!pins_in.comp_out && pins_prev.comp_out)
	                              : (!pins_in.pin5 && pins_prev.pin5); // [RULE12] [RULE14]

	// Bit order sets priority: bit 0 is the most urgent source
	wire [7:0] events = {fall7, rise6, input_port_fall_irq_in, pin_edge_irq_in,
	                     second_timer_underflow_irq_in, first_timer_underflow_irq_in,
	                     converter_timer_underflow_irq_in}; // [RULE3] [RULE4]

	// ******************************
	// Flags and service
	// ******************************
	wire [7:0] serve       = events & ctrl.service_enable_mask; // [RULE2]
	wire [7:0] flag_base   = wr_flag ? port_wdata_in[7:0] : flags;
	// Unserviced events win over a software clear in the same cycle
	wire [7:0] next_flags  = (flag_base | (events & ~ctrl.service_enable_mask))
	                         & ~serve; // [RULE13]

	// Comparator falling edge starts timer one only while its run bit is clear
	wire next_t1_cmp = ctrl.comp_enable && !ctrl.first_timer_run &&
	                   ((fall7 && !rise6) || (t1_cmp_run && !rise6)); // [RULE14]
	igc_ctrl_type next_ctrl;
	assign next_ctrl = wr_ctrl ? igc_ctrl_type'(port_wdata_in) : ctrl; // [RULE15]

	// Run bit comes from the value being written, so a start shows in the same cycle as the run bit
	wire next_t1_act = next_ctrl.first_timer_run || next_t1_cmp; // [RULE7]

	// ******************************
	// Registers
	// ******************************
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			ctrl <= igc_ctrl_type'(`IGC_CTRL_RESET); // [RULE5]
			pins_prev <= '0;
			t1_cmp_run <= 1'b0;
			first_timer_active_out <= 1'b0;
			service_out <= 8'h00;
			port_rdata_out <= 16'h0000;
		end else if (ce_in) begin
			ctrl <= next_ctrl;
			pins_prev <= pins_in;
			t1_cmp_run <= next_t1_cmp;
			first_timer_active_out <= next_t1_act;
			service_out <= serve;
			if (rd_ctrl) begin
				port_rdata_out <= ctrl; // [RULE15]
			end else if (rd_flag) begin
				port_rdata_out <= {8'h00, flags};
			end else begin
				port_rdata_out <= 16'h0000;
			end
		end
	end

	// Flags survive reset, as the flag register is not cleared by it
	always_ff @(posedge mclk_in) begin
		if (ce_in) begin
			flags <= next_flags;
		end
	end

	// Every field leaves straight from the register flops
	assign ctrl_out = ctrl; // [RULE6] [RULE8] [RULE9] [RULE10] [RULE12]
	assign interrupt_flag_out = flags;

	// ******************************
	// Checks
	// ******************************
	property p_write;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl) |=> (ctrl_out == $past(port_wdata_in));
	endproperty
	a_write: assert property (p_write) else $error("control write not stored"); // [RULE15]

	property p_decode;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && port_wr_in && port_addr_in != `IGC_CTRL_ADDR) |=> $stable(ctrl_out);
	endproperty
	a_decode: assert property (p_decode) else $error("foreign address changed control"); // [RULE1]

	property p_reset;
		@(posedge mclk_in) srst_in |=> (ctrl_out == 16'h0000);
	endproperty
	a_reset: assert property (p_reset) else $error("control not cleared by reset"); // [RULE5]

	property p_read;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && rd_ctrl) |=> (port_rdata_out == $past(ctrl_out));
	endproperty
	a_read: assert property (p_read) else $error("read data wrong"); // [RULE15]

	property p_serve;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && converter_timer_underflow_irq_in && ctrl_out.service_enable_mask[0])
		|=> (service_out[0] && !interrupt_flag_out[0]);
	endproperty
	a_serve: assert property (p_serve) else $error("masked-in event not serviced"); // [RULE2]

	property p_pend;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && input_port_fall_irq_in && !ctrl_out.service_enable_mask[5])
		|=> (interrupt_flag_out[5] && !service_out[5]);
	endproperty
	a_pend: assert property (p_pend) else $error("masked-out event lost or serviced"); // [RULE13]

	property p_pullup;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl) |=> (ctrl_out.input_pullup_on == $past(port_wdata_in[`IGC_BIT_PULLUP]));
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up bit wrong"); // [RULE8]

	property p_t1start;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && !wr_ctrl && ctrl.comp_enable && !ctrl.first_timer_run && fall7 && !rise6)
		|=> first_timer_active_out;
	endproperty
	a_t1start: assert property (p_t1start) else $error("comparator fall did not start timer"); // [RULE14]

	property p_t1run;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl && port_wdata_in[`IGC_BIT_T1_RUN]) |=> first_timer_active_out;
	endproperty
	a_t1run: assert property (p_t1run) else $error("run bit did not start timer"); // [RULE7]

	// ******************************
	// Field checks
	// ******************************
	property p_mask;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl) |=> (ctrl_out.service_enable_mask == $past(port_wdata_in[7:0]));
	endproperty
	a_mask: assert property (p_mask) else $error("mask field wrong"); // [RULE2]

	property p_clk1;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl) |=> (ctrl_out.first_timer_clk_sel == $past(port_wdata_in[`IGC_BIT_T1_CLK]));
	endproperty
	a_clk1: assert property (p_clk1) else $error("timer one clock select wrong"); // [RULE6]

	property p_clk2;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl) |=> (ctrl_out.second_timer_clk_sel == $past(port_wdata_in[`IGC_BIT_T2_CLK]));
	endproperty
	a_clk2: assert property (p_clk2) else $error("timer two clock select wrong"); // [RULE6]

	property p_run1;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl) |=> (ctrl_out.first_timer_run == $past(port_wdata_in[`IGC_BIT_T1_RUN]));
	endproperty
	a_run1: assert property (p_run1) else $error("timer one run bit wrong"); // [RULE7]

	property p_run2;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl) |=> (ctrl_out.second_timer_run == $past(port_wdata_in[`IGC_BIT_T2_RUN]));
	endproperty
	a_run2: assert property (p_run2) else $error("timer two run bit wrong"); // [RULE7]

	property p_pdm;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl) |=> (ctrl_out.pdm_rate_select == $past(port_wdata_in[`IGC_BIT_PDM]));
	endproperty
	a_pdm: assert property (p_pdm) else $error("pdm rate bit wrong"); // [RULE9]

	property p_wake;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl) |=> (ctrl_out.async_wake_arm == $past(port_wdata_in[`IGC_BIT_WAKE]));
	endproperty
	a_wake: assert property (p_wake) else $error("wake arm bit wrong"); // [RULE10]

	property p_comp;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_ctrl) |=> (ctrl_out.comp_enable == $past(port_wdata_in[`IGC_BIT_COMP]));
	endproperty
	a_comp: assert property (p_comp) else $error("comparator enable wrong"); // [RULE12]

	// ******************************
	// Bus, reset and event checks
	// ******************************
	property p_rd_flag;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && rd_flag) |=> (port_rdata_out == {8'h00, $past(interrupt_flag_out)});
	endproperty
	a_rd_flag: assert property (p_rd_flag) else $error("flag read wrong"); // [RULE13]

	property p_rd_idle;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && !port_rd_in) |=> (port_rdata_out == 16'h0000);
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle"); // [RULE15]

	property p_reset_out;
		@(posedge mclk_in)
		srst_in |=> (port_rdata_out == 16'h0000 && service_out == 8'h00 &&
		             !first_timer_active_out);
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset"); // [RULE5]

	property p_ce_freeze;
		@(posedge mclk_in) disable iff (srst_in)
		!ce_in |=> ($stable(ctrl_out) && $stable(port_rdata_out) && $stable(service_out) &&
		            $stable(first_timer_active_out));
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled"); // [RULE15]

	property p_t1stop;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && !wr_ctrl && !ctrl.first_timer_run && rise6)
		|=> !first_timer_active_out;
	endproperty
	a_t1stop: assert property (p_t1stop) else $error("comparator rise did not stop timer"); // [RULE14]

	property p_rise6;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && ctrl.comp_enable && pins_in.comp_out && !pins_prev.comp_out)
		|=> (interrupt_flag_out[6] || service_out[6]);
	endproperty
	a_rise6: assert property (p_rise6) else $error("comparator rise missed"); // [RULE14]

	property p_fall7;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && ctrl.comp_enable && !pins_in.comp_out && pins_prev.comp_out)
		|=> (interrupt_flag_out[7] || service_out[7]);
	endproperty
	a_fall7: assert property (p_fall7) else $error("comparator fall missed"); // [RULE14]

	property p_pin6;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && !ctrl.comp_enable && pins_in.pin4 && !pins_prev.pin4)
		|=> (interrupt_flag_out[6] || service_out[6]);
	endproperty
	a_pin6: assert property (p_pin6) else $error("pin rise missed"); // [RULE12]

	property p_pin7;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && !ctrl.comp_enable && !pins_in.pin5 && pins_prev.pin5)
		|=> (interrupt_flag_out[7] || service_out[7]);
	endproperty
	a_pin7: assert property (p_pin7) else $error("pin fall missed"); // [RULE12]

	property p_quiet;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && events == 8'h00) |=> (service_out == 8'h00);
	endproperty
	a_quiet: assert property (p_quiet) else $error("service without event"); // [RULE2]

	property p_pri1;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && first_timer_underflow_irq_in && ctrl.service_enable_mask[1])
		|=> (service_out[1] && !interrupt_flag_out[1]);
	endproperty
	a_pri1: assert property (p_pri1) else $error("interrupt one not on its bit"); // [RULE3]

	property p_flag_sw;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && wr_flag && events == 8'h00)
		|=> (interrupt_flag_out == $past(port_wdata_in[7:0]));
	endproperty
	a_flag_sw: assert property (p_flag_sw) else $error("flag write not stored"); // [RULE13]

	property p_srv7;
		@(posedge mclk_in) disable iff (srst_in)
		(ce_in && ctrl.comp_enable && fall7 && ctrl.service_enable_mask[7])
		|=> service_out[7];
	endproperty
	a_srv7: assert property (p_srv7) else $error("interrupt seven not serviced"); // [RULE14]

endmodule
`default_nettype wire

/* dv/igc_core_model.sv */
// Processor core model issuing I/O port reads and writes
`default_nettype none
module igc_core_model (
	// Clock
	input  wire logic        mclk_in,
	// I/O port bus
	output logic [7:0]       port_addr_out,
	output logic             port_wr_out,
	output logic             port_rd_out,
	output logic [15:0]      port_wdata_out,
	input  wire logic [15:0] port_rdata_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		port_addr_out = 8'h00;
		port_wr_out = 1'b0;
		port_rd_out = 1'b0;
		port_wdata_out = 16'h0000;
	end
	// Released address and data lines show the inverse, and the strobes drop to zero, so stale values cannot pass
	task automatic access(input logic [7:0] a, input logic wr, input logic [15:0] d,
			output logic [15:0] q);
		@(posedge mclk_in);
		#1;
		port_addr_out = a;
		port_wdata_out = d;
		port_wr_out = wr;
		port_rd_out = !wr;
		@(posedge mclk_in);
		#1;
		q = port_rdata_in;
		port_wr_out = 1'b0;
		port_rd_out = 1'b0;
		port_addr_out = ~a;
		port_wdata_out = ~d;
	endtask
endmodule
`default_nettype wire

/* dv/interrupt_general_control_reg_tb.sv */
// Self-checking bench for the interrupt and general control register
`default_nettype none
module interrupt_general_control_reg_tb
	import igc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
	logic clk = 0, rst = 1, wr, rd;
	logic [7:0] addr, flg, srv, trig = 0;
	logic [15:0] wd, rdat, q;
	igc_pins_type pins = '0;
	igc_ctrl_type ctrl;
	logic t1;
	logic ce = 1;
	int error_cnt = 0, tests_run = 0;
	always #10 clk = ~clk;
	igc_core_model u_core (.mclk_in(clk), .port_addr_out(addr), .port_wr_out(wr),
		.port_rd_out(rd), .port_wdata_out(wd), .port_rdata_in(rdat));
	igc_ctrl u_dut (.mclk_in(clk), .srst_in(rst), .ce_in(ce), .port_addr_in(addr),
		.port_wr_in(wr), .port_rd_in(rd), .port_wdata_in(wd), .port_rdata_out(rdat),
		.converter_timer_underflow_irq_in(trig[0]), .first_timer_underflow_irq_in(trig[1]),
		.second_timer_underflow_irq_in(trig[2]), .pin_edge_irq_in(trig[4:3]),
		.input_port_fall_irq_in(trig[5]), .pins_in(pins), .ctrl_out(ctrl),
		.first_timer_active_out(t1), .interrupt_flag_out(flg), .service_out(srv));
	task automatic wr_r(input logic [7:0] a, input logic [15:0] d);
		u_core.access(a, 1'b1, d, q);
	endtask
	task automatic rd_r(input logic [7:0] a);
		u_core.access(a, 1'b0, 16'h0000, q);
	endtask
	task automatic t_bits();
		for (int k = 0; k < 16; k++) begin
			wr_r(8'h38, 16'h0001 << k);
			`CHK("ctrl", 16'h0001 << k, ctrl)
			rd_r(8'h38);
			`CHK("read", 16'h0001 << k, q)
		end
		wr_r(8'h3a, 16'hffff);
		`CHK("ctrl kept", 16'h8000, ctrl)
		rd_r(8'h3a);
		`CHK("unmapped", 16'h0000, q)
	endtask
	task automatic t_reset();
		wr_r(8'h38, 16'hffff);
		@(posedge clk);
		#1 rst = 1;
		repeat (2) @(posedge clk);
		#1 rst = 0;
		`CHK("reset", 16'h0000, ctrl)
		rd_r(8'h38);
		`CHK("reset read", 16'h0000, q)
	endtask
	task automatic t_irq();
		wr_r(8'h39, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			wr_r(8'h38, 16'h0000);
			@(posedge clk);
			#1 trig = 8'h01 << i;
			@(posedge clk);
			#1 trig = 0;
			`CHK("flag", 8'h01 << i, flg & (8'h01 << i))
			rd_r(8'h39);
			`CHK("flag read", 16'h0001 << i, q)
			wr_r(8'h38, 16'h0001 << i);
			@(posedge clk);
			#1 trig = 8'h01 << i;
			@(posedge clk);
			#1 trig = 0;
			`CHK("service", 8'h01 << i, srv)
			`CHK("flag clr", 8'h00, flg & (8'h01 << i))
		end
	endtask
	task automatic t_comp();
		wr_r(8'h39, 16'h0000);
		wr_r(8'h38, 16'h8000);
		pins.comp_out = 1;
		repeat (2) @(posedge clk);
		#1 `CHK("rise", 8'h40, flg)
		wr_r(8'h39, 16'h0000);
		pins.comp_out = 0;
		repeat (2) @(posedge clk);
		#1 `CHK("fall", 8'h80, flg)
		`CHK("start", 1'b1, t1)
		pins.comp_out = 1;
		repeat (2) @(posedge clk);
		#1 `CHK("stop", 1'b0, t1)
	endtask
	task automatic t_ce();
		wr_r(8'h38, 16'h0123);
		ce = 0;
		wr_r(8'h38, 16'h0456);
		ce = 1;
		`CHK("frozen", 16'h0123, ctrl)
		rd_r(8'h38);
		`CHK("after freeze", 16'h0123, q)
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1 rst = 0;
		t_bits();
		t_reset();
		t_irq();
		t_ce();
		t_comp();
		give_verdict();
	end
	initial begin
		#100000;
		error_cnt++;
		give_verdict();
	end
endmodule
`default_nettype wire
